// ===== logic/dfs_pkg.sv
// Purpose: Shared constants and carriers for the DDS frequency synthesizer core
// Assumes: 50 MHz reference clock, control words presented as plain ports
// Notes:   Field positions follow the 24-bit control word layout
package dfs_pkg;

  localparam int ACC_W      = 24;
  localparam int SET_W      = 22;
  localparam int DEV_W      = 8;
  localparam int DEV_SHIFT  = 2;
  localparam int ACCEL_W    = 3;
  localparam int WORD_W     = 24;

  // Field positions inside the control words
  localparam int A_SET_LSB  = 0;
  localparam int B_SET_LSB  = 0;
  localparam int D_DEV_LSB  = 13;
  localparam int C_MOD_BIT  = 16;
  localparam int C_DIV_BIT  = 17;
  localparam int C_ACC_LSB  = 18;
  localparam int X_OSC_BIT  = 11;

  // Reset values
  localparam logic [SET_W-1:0]   SET_RST   = 22'h000000;
  localparam logic [DEV_W-1:0]   DEV_RST   = 8'h00;
  localparam logic [ACCEL_W-1:0] ACCEL_RST = 3'h0;
  localparam logic               DIV_RST   = 1'b0;
  localparam logic               MOD_RST   = 1'b0;
  localparam logic [ACC_W-1:0]   ACC_RST   = 24'h000000;

  // Divider ratios
  localparam int DIV_LOW  = 256;
  localparam int DIV_HIGH = 512;

  typedef enum logic [1:0] {
    DFS_IDLE  = 2'b00,
    DFS_RUN   = 2'b01,
    DFS_ACQ   = 2'b10
  } dfs_state_e;

  typedef struct packed {
    logic [SET_W-1:0]   mode0_freq_setting;
    logic [SET_W-1:0]   mode1_freq_setting;
    logic [DEV_W-1:0]   fsk_deviation;
    logic               modulation_select;
    logic               divider_ratio_sel;
    logic [ACCEL_W-1:0] acquisition_accel;
    logic [1:0]         osc_enable_per_mode;
  } dfs_cfg_s;

endpackage

// ===== logic/dfs_sine_rom.sv
// Purpose: Full-period sine lookup from accumulator phase
// Assumes: Registered output, one cycle latency
// Notes:   Table is filled by an initial block at time zero
`timescale 1ns/1ps
module dfs_sine_rom #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 11
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] phase,
  output logic      [DATA_W-1:0] sample
);

  localparam int DEPTH = 1 << ADDR_W;
  localparam real PI   = 3.14159265358979;

  logic [DATA_W-1:0] table_q [DEPTH];

  // Offset-binary sine sample for one table slot
  function automatic logic [DATA_W-1:0] sineAt(input int idx);
    real r;
    r = $sin(2.0 * PI * idx / DEPTH);
    return DATA_W'($rtoi((r + 1.0) * (((1 << DATA_W) - 1) / 2.0)));
  endfunction

  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      table_q[i] = sineAt(i);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sample <= '0;
    end else begin
      sample <= table_q[phase];
    end
  end

endmodule

// ===== logic/dfs_core.sv
// Purpose: Phase accumulator, frequency word selection and PLL control outputs
// Assumes: Control words held steady by the programming side; pins synchronous to clk
// Notes:   Accumulator phase never restarts except on reset
`timescale 1ns/1ps
module dfs_core #(
  parameter int ROM_ADDR_W = 8,
  parameter int DAC_W      = 11
) (
  input  wire logic                            clk,
  input  wire logic                            rst,
  input  wire logic                            cfgLoadA,
  input  wire logic                            cfgLoadB,
  input  wire logic                            cfgLoadC,
  input  wire logic                            cfgLoadD,
  input  wire logic [dfs_pkg::WORD_W-1:0]      cfgWord,
  input  wire logic                            standby,
  input  wire logic                            modeSel,
  input  wire logic                            txData,
  input  wire logic                            pllLocked,
  output logic      [dfs_pkg::ACC_W-1:0]       phaseAcc,
  output logic      [DAC_W-1:0]                dacSample,
  output logic      [dfs_pkg::ACC_W-1:0]       freqWord,
  output logic                                 divideBy512,
  output logic                                 acquisition_pump_out,
  output logic      [dfs_pkg::ACCEL_W-1:0]     pumpGain,
  output logic                                 oscEnable
);

  dfs_pkg::dfs_cfg_s cfg_q;
  logic [dfs_pkg::ACC_W-1:0] acc_q;
  logic [dfs_pkg::ACC_W-1:0] word_q;
  logic [dfs_pkg::ACC_W-1:0] word_d;
  logic [DAC_W-1:0]          sample;
  dfs_pkg::dfs_state_e       state_q;

  // Zero-extend a 22-bit setting into the 24-bit frequency word
  function automatic logic [dfs_pkg::ACC_W-1:0] widen(input logic [dfs_pkg::SET_W-1:0] s);
    return {{(dfs_pkg::ACC_W - dfs_pkg::SET_W){1'b0}}, s};
  endfunction

  // Settings are static; standby does not touch them
  // settings retained in standby
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_q.mode0_freq_setting <= dfs_pkg::SET_RST;
      cfg_q.mode1_freq_setting <= dfs_pkg::SET_RST;
      cfg_q.fsk_deviation      <= dfs_pkg::DEV_RST;
      cfg_q.modulation_select  <= dfs_pkg::MOD_RST;
      cfg_q.divider_ratio_sel  <= dfs_pkg::DIV_RST;
      cfg_q.acquisition_accel  <= dfs_pkg::ACCEL_RST;
      cfg_q.osc_enable_per_mode <= 2'h0;
    end else begin
      if (cfgLoadA) begin
        cfg_q.mode0_freq_setting <= cfgWord[dfs_pkg::A_SET_LSB +: dfs_pkg::SET_W];
      end
      if (cfgLoadB) begin
        cfg_q.mode1_freq_setting <= cfgWord[dfs_pkg::B_SET_LSB +: dfs_pkg::SET_W];
      end
      // divider bit and accel field from C word
      if (cfgLoadC) begin
        cfg_q.modulation_select  <= cfgWord[dfs_pkg::C_MOD_BIT];
        cfg_q.divider_ratio_sel  <= cfgWord[dfs_pkg::C_DIV_BIT];
        cfg_q.acquisition_accel  <= cfgWord[dfs_pkg::C_ACC_LSB +: dfs_pkg::ACCEL_W];
        // mode-1 oscillator enable owned by controller
        cfg_q.osc_enable_per_mode[1] <= cfgWord[dfs_pkg::X_OSC_BIT];
      end
      if (cfgLoadD) begin
        cfg_q.fsk_deviation          <= cfgWord[dfs_pkg::D_DEV_LSB +: dfs_pkg::DEV_W];
        cfg_q.osc_enable_per_mode[0] <= cfgWord[dfs_pkg::X_OSC_BIT];
      end
    end
  end

  // top two bits of the word stay zero unless deviation is added
  // deviation only with modulation select clear
  // deviation scaled by four when data high
  always_comb begin
    word_d = widen(modeSel ? cfg_q.mode1_freq_setting : cfg_q.mode0_freq_setting);
    if (!cfg_q.modulation_select && txData) begin
      word_d = dfs_pkg::ACC_W'(word_d + (dfs_pkg::ACC_W'(cfg_q.fsk_deviation) << dfs_pkg::DEV_SHIFT));
    end
  end

  // word reload never touches the phase
  always_ff @(posedge clk) begin
    if (rst) begin
      word_q <= dfs_pkg::ACC_RST;
    end else begin
      word_q <= word_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_q <= dfs_pkg::ACC_RST;
    end else begin
      acc_q <= dfs_pkg::ACC_W'(acc_q + word_q);
    end
  end

  // phase top bits address sine table
  dfs_sine_rom #(
    .ADDR_W (ROM_ADDR_W),
    .DATA_W (DAC_W)
  ) u_rom (
    .clk    (clk),
    .rst    (rst),
    .phase  (acc_q[dfs_pkg::ACC_W-1 -: ROM_ADDR_W]),
    .sample (sample)
  );

  // Lock tracking for the acquisition aid
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= dfs_pkg::DFS_IDLE;
    end else begin
      case (state_q)
        dfs_pkg::DFS_IDLE: begin
          if (!standby) begin
            state_q <= pllLocked ? dfs_pkg::DFS_RUN : dfs_pkg::DFS_ACQ;
          end
        end
        dfs_pkg::DFS_ACQ: begin
          if (standby) begin
            state_q <= dfs_pkg::DFS_IDLE;
          end else if (pllLocked) begin
            state_q <= dfs_pkg::DFS_RUN;
          end
        end
        dfs_pkg::DFS_RUN: begin
          if (standby) begin
            state_q <= dfs_pkg::DFS_IDLE;
          end else if (!pllLocked) begin
            state_q <= dfs_pkg::DFS_ACQ;
          end
        end
        default: begin
          state_q <= dfs_pkg::DFS_IDLE;
        end
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      phaseAcc             <= dfs_pkg::ACC_RST;
      dacSample            <= '0;
      freqWord             <= dfs_pkg::ACC_RST;
      divideBy512          <= dfs_pkg::DIV_RST;
      acquisition_pump_out <= 1'b0;
      pumpGain             <= dfs_pkg::ACCEL_RST;
      oscEnable            <= 1'b0;
    end else begin
      phaseAcc             <= acc_q;
      dacSample            <= sample;
      freqWord             <= word_q;
      divideBy512          <= cfg_q.divider_ratio_sel;
      acquisition_pump_out <= (state_q == dfs_pkg::DFS_ACQ) && !pllLocked;
      pumpGain             <= cfg_q.acquisition_accel;
      oscEnable            <= cfg_q.osc_enable_per_mode[modeSel];
    end
  end

  a_acc_step: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> acc_q == 24'($past(acc_q) + $past(word_q)))
    else $error("accumulator step wrong");

  a_word_top: assert property (@(posedge clk) disable iff (rst)
    (cfg_q.modulation_select || !txData) |-> word_d[23:22] == 2'h0)
    else $error("frequency word top bits set");

  a_mode_pick: assert property (@(posedge clk) disable iff (rst)
    !txData |=> word_q == widen($past(modeSel) ? $past(cfg_q.mode1_freq_setting)
                                               : $past(cfg_q.mode0_freq_setting)))
    else $error("mode setting not selected");

  a_fsk_gate: assert property (@(posedge clk) disable iff (rst)
    cfg_q.modulation_select |-> word_d == widen(modeSel ? cfg_q.mode1_freq_setting : cfg_q.mode0_freq_setting))
    else $error("deviation applied with modulation select set");

  a_fsk_dev: assert property (@(posedge clk) disable iff (rst)
    (!cfg_q.modulation_select && txData) |=>
      word_q == 24'(widen($past(modeSel) ? $past(cfg_q.mode1_freq_setting)
                    : $past(cfg_q.mode0_freq_setting)) + {14'h0, $past(cfg_q.fsk_deviation), 2'h0}))
    else $error("deviation not four times value");

  a_keep_std: assert property (@(posedge clk) disable iff (rst)
    (standby && !cfgLoadA) |=> $stable(cfg_q.mode0_freq_setting))
    else $error("setting lost in standby");

  a_div_sel: assert property (@(posedge clk) disable iff (rst)
    cfgLoadC |-> ##2 divideBy512 == $past(cfgWord[17], 2))
    else $error("divider select wrong");

  a_pump_lock: assert property (@(posedge clk) disable iff (rst)
    pllLocked |=> !acquisition_pump_out)
    else $error("acquisition pump on while locked");

  a_gain_map: assert property (@(posedge clk) disable iff (rst)
    cfgLoadC |-> ##2 pumpGain == $past(cfgWord[20:18], 2))
    else $error("acceleration field wrong");

  a_dev_load: assert property (@(posedge clk) disable iff (rst)
    cfgLoadD |=> cfg_q.fsk_deviation == $past(cfgWord[20:13]))
    else $error("deviation field wrong");

  a_mode0_load: assert property (@(posedge clk) disable iff (rst)
    cfgLoadA |=> cfg_q.mode0_freq_setting == $past(cfgWord[21:0]))
    else $error("mode-0 field wrong");

  a_phase_keep: assert property (@(posedge clk) disable iff (rst)
    $changed(modeSel) |=> acc_q != 24'h000000 || $past(acc_q) + $past(word_q) == 25'h0000000
                          || $past(acc_q) + $past(word_q) == 25'h1000000)
    else $error("phase restarted on mode change");

  a_rst_clr: assert property (@(posedge clk)
    rst |=> acc_q == 24'h000000)
    else $error("accumulator not cleared by reset");

endmodule

// ===== verification/dfs_pll_model.sv
// Purpose: Behavioural loop model facing the core's acquisition pump output
// Assumes: Loop locks after LOCK_CYC cycles of acquisition pumping
// Notes:   kick from the bench throws the loop out of lock
`timescale 1ns/1ps
module dfs_pll_model #(
  parameter int LOCK_CYC = 8
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pumpOn,
  input  wire logic kick,
  output logic      pllLocked
);
  int pumpCnt_q;

  always_ff @(posedge clk) begin
    if (rst || kick) begin
      pumpCnt_q <= 0;
      pllLocked <= 1'b0;
    end else if (pumpOn) begin
      pumpCnt_q <= pumpCnt_q + 1;
      if (pumpCnt_q >= LOCK_CYC - 1) begin
        pllLocked <= 1'b1;
      end
    end
  end
endmodule

// ===== verification/dfs_core_tb.sv
// Purpose: Self-checking bench for the synthesizer core
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Loop lock comes from the behavioural loop model
`timescale 1ns/1ps
module dfs_core_tb;
  logic        clk, rst, standby, modeSel, txData, pllLocked, kick;
  logic [3:0]  ld;
  logic [23:0] cfgWord, phaseAcc, freqWord;
  logic [10:0] dacSample;
  logic [2:0]  pumpGain;
  logic        divideBy512, pumpOut, oscEnable;
  int          n_fail, num_checks;

  dfs_core dut (.clk(clk), .rst(rst), .cfgLoadA(ld[0]), .cfgLoadB(ld[1]), .cfgLoadC(ld[2]),
    .cfgLoadD(ld[3]), .cfgWord(cfgWord), .standby(standby), .modeSel(modeSel), .txData(txData),
    .pllLocked(pllLocked), .phaseAcc(phaseAcc), .dacSample(dacSample), .freqWord(freqWord),
    .divideBy512(divideBy512), .acquisition_pump_out(pumpOut), .pumpGain(pumpGain),
    .oscEnable(oscEnable));
  dfs_pll_model pll (.clk(clk), .rst(rst), .pumpOn(pumpOut), .kick(kick), .pllLocked(pllLocked));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic load(input int sel, input logic [23:0] w);
    cfgWord = w;
    ld = 4'h1 << sel;
    tick(1);
    ld = 4'h0;
    cfgWord = 24'h0;
    tick(4);
  endtask

  task automatic chkStep(input logic [23:0] exp);
    logic [23:0] p0;
    p0 = phaseAcc;
    tick(1);
    chk("phase step", phaseAcc - p0, exp);
  endtask

  task automatic t_reset();
    chk("phase", phaseAcc, 24'h0);
    chk("word", freqWord, 24'h0);
    chk("divider", {23'h0, divideBy512}, 24'h0);
    chk("sample", {13'h0, dacSample}, 24'h3ff);
  endtask

  task automatic t_mode();
    logic [23:0] d, p;
    load(0, 24'hffffff);
    chk("word a", freqWord, 24'h3fffff);
    repeat (6) chkStep(24'h3fffff);
    load(1, 24'h123456);
    p = phaseAcc;
    modeSel = 1'b1;
    repeat (5) begin
      tick(1);
      d = phaseAcc - p;
      p = phaseAcc;
      chk("continuity", {23'h0, d === 24'h3fffff || d === 24'h123456}, 24'h1);
    end
    chk("word b", freqWord, 24'h123456);
    chkStep(24'h123456);
    modeSel = 1'b0;
    tick(4);
    chk("word back", freqWord, 24'h3fffff);
  endtask

  task automatic t_fsk();
    // external source on mode1: its enable stays cleared
    load(3, 24'h1fe800);
    load(2, 24'h000000);
    txData = 1'b1;
    tick(4);
    chk("fsk word", freqWord, 24'h4003fb);
    chkStep(24'h4003fb);
    chk("osc mode0", {23'h0, oscEnable}, 24'h1);
    modeSel = 1'b1;
    tick(4);
    chk("osc mode1", {23'h0, oscEnable}, 24'h0);
    modeSel = 1'b0;
    load(2, 24'h010000);
    chk("fm word", freqWord, 24'h3fffff);
    txData = 1'b0;
    load(2, 24'h000000);
    chk("fsk low", freqWord, 24'h3fffff);
  endtask

  task automatic t_ctl();
    for (int i = 0; i < 8; i++) begin
      load(2, (24'(i) << 18) | (24'(i & 1) << 17));
      chk("gain", {21'h0, pumpGain}, 24'(i));
      chk("divider", {23'h0, divideBy512}, 24'(i & 1));
    end
  endtask

  task automatic t_lock();
    int n;
    kick = 1'b1;
    tick(1);
    kick = 1'b0;
    n = 0;
    while (pumpOut !== 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    chk("pump on", {23'h0, pumpOut}, 24'h1);
    n = 0;
    while (pumpOut !== 1'b0 && n < 20) begin
      tick(1);
      n++;
    end
    chk("pump off", {23'h0, pumpOut}, 24'h0);
    kick = 1'b1;
    standby = 1'b1;
    tick(1);
    kick = 1'b0;
    tick(6);
    chk("standby pump", {23'h0, pumpOut}, 24'h0);
    standby = 1'b0;
    tick(4);
    chk("kept word", freqWord, 24'h3fffff);
  endtask

  // Mid-run reset, then quarter points of the sine table at 1/8 turn per clock
  task automatic t_sine();
    logic [7:0] p;
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(3);
    t_reset();
    chk("gain reset", {21'h0, pumpGain}, 24'h0);
    load(0, 24'h200000);
    chkStep(24'h200000);
    repeat (16) begin
      p = phaseAcc[23:16];
      tick(1);
      if (p == 8'h40) begin
        chk("sine peak", {13'h0, dacSample}, 24'h7ff);
      end else if (p == 8'hc0) begin
        chk("sine trough", {13'h0, dacSample}, 24'h0);
      end else if (p[5:0] == 6'h0) begin
        chk("sine mid", {13'h0, dacSample}, 24'h3ff);
      end
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    results();
  end

  initial begin
    rst = 1'b1;
    ld = 4'h0;
    cfgWord = 24'h0;
    standby = 1'b0;
    modeSel = 1'b0;
    txData = 1'b0;
    kick = 1'b0;
    tick(2);
    rst = 1'b0;
    tick(3);
    t_reset();
    t_mode();
    t_fsk();
    t_ctl();
    t_lock();
    t_sine();
    results();
  end
endmodule
